/* File: verilog/sdrc_pkg.sv */
// Constants and carrier types for the delta-sigma converter result and control block
package sdrc_pkg;
  // Byte offsets of the register port
  localparam logic [7:0] ADDR_AMP_CHAN = 8'h01;
  localparam logic [7:0] ADDR_AMP_INPUT = 8'h02;
  localparam logic [7:0] ADDR_SAMPLE_LOW = 8'h04;
  localparam logic [7:0] ADDR_SAMPLE_MID = 8'h05;
  localparam logic [7:0] ADDR_SAMPLE_HIGH = 8'h06;
  localparam logic [7:0] ADDR_CTL_A = 8'h07;
  localparam logic [7:0] ADDR_CTL_B = 8'h08;
  localparam logic [7:0] ADDR_CLK_SETUP = 8'h09;
  // Field positions in converter_control_a
  localparam int CA_SLEEP_BIT = 7;
  localparam int CA_FRST_BIT = 6;
  localparam int CA_OFF_BIT = 5;
  localparam int CA_OSR_LSB = 1;
  localparam int CA_REFSEL_BIT = 0;
  // Field positions in converter_control_b
  localparam int CB_FILTER_RATIO_SELECT_LSB = 5;
  localparam int CB_NBUF_BIT = 4;
  localparam int CB_PBUF_BIT = 3;
  localparam int CB_HOLD_BIT = 2;
  localparam int CB_DONE_BIT = 1;
  // Field positions in the amplifier and clock registers
  localparam int AC_POS_LSB = 0;
  localparam int AC_NEG_LSB = 3;
  localparam int AI_VCM_BIT = 0;
  localparam int CH_W = 3;
  localparam int OSR_W = 4;
  localparam int FILTER_RATIO_SELECT_W = 3;
  localparam int CKDIV_W = 5;
  // Reset values
  localparam logic [7:0] CTL_A_RST = 8'h20;
  localparam logic [7:0] CTL_B_RST = 8'h00;
  localparam logic [7:0] CLK_SETUP_RST = 8'h00;
  localparam logic [7:0] AMP_CHAN_RST = 8'h00;
  localparam logic [7:0] AMP_INPUT_RST = 8'h00;
  // Used bits of each writable register
  localparam logic [7:0] CTL_B_MASK = 8'hFE;
  localparam logic [7:0] CLK_SETUP_MASK = 8'h1F;
  localparam logic [7:0] AMP_CHAN_MASK = 8'h3F;
  localparam logic [7:0] AMP_INPUT_MASK = 8'h01;
  // Result coding
  localparam int RESULT_W = 24;
  localparam logic [23:0] RES_MAX = 24'h7FFFFF;
  localparam logic [23:0] RES_MIN = 24'h800000;
  // Channel code that routes the temperature sensor
  localparam logic [2:0] TEMP_CH_CODE = 3'h7;
  // Operating modes
  typedef enum logic [1:0] {MODE_PDOWN, MODE_SLEEP, MODE_NORMAL, MODE_RESET} sdrc_mode_t;
  // Analog enables driven to the front end
  typedef struct packed {
    logic bandgap_en;
    logic pga_en;
    logic adc_en;
    logic temp_sense_en;
    logic neg_ref_buffer_en;
    logic pos_ref_buffer_en;
    logic filter_en;
    logic filter_reset;
    logic common_mode_gen_en;
    logic reference_pair_ext;
  } sdrc_ana_t;
  // Setup fields passed through to clock and filter logic
  typedef struct packed {
    logic [CKDIV_W-1:0] clock_divider_select;
    logic [OSR_W-1:0] oversampling_select;
    logic [FILTER_RATIO_SELECT_W-1:0] filter_ratio_select;
    logic [CH_W-1:0] positive_input_select;
    logic [CH_W-1:0] negative_input_select;
  } sdrc_cfg_t;
endpackage

/* File: verilog/sdrc_core.sv */
// Control, result path and register port of the delta-sigma converter
// What this block does
// - Converts only with power-off and sleep cleared
// - Filter reset pulse restarts the decimation filter
// - Done flag set when each conversion finishes without hold
// - Without hold, every conversion overwrites the result
// - With hold, keep result, discard later conversions
// - Hold stops updates; done flag stays unchanged
// - Power-off beats sleep; sleep beats filter reset
// - Reference pair select picks internal or external
// - Result is 24-bit two's complement, sign MSB
// - Saturate to 8388607 and -8388608
// - Full scale codes and zero centre code
// - Result bytes read-only at 04H, 05H, 06H
// - Input selects switch the temperature sensor
// - Each reference buffer has its own enable
// - Common-mode generator has its own enable
`timescale 1ns/1ps
`default_nettype none
module sdrc_core #(
  parameter int RAW_W = 26 // Width of the filter output before clamping
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Decimation filter output stream
  input wire logic filt_valid_i,
  input wire logic signed [RAW_W-1:0] filt_data_i,
  output logic filt_ready_o,
  // Front-end controls
  output sdrc_pkg::sdrc_ana_t ana_o,
  output sdrc_pkg::sdrc_cfg_t cfg_o,
  output sdrc_pkg::sdrc_mode_t mode_o
);

  // Clamp limits at the filter width
  localparam logic signed [RAW_W-1:0] HI_LIM = {{(RAW_W-24){1'b0}}, sdrc_pkg::RES_MAX};
  localparam logic signed [RAW_W-1:0] LO_LIM = {{(RAW_W-24){1'b1}}, sdrc_pkg::RES_MIN};

  // Software visible registers
  logic [7:0] ctl_a_q; // Power, sleep, filter reset, oversampling, reference
  logic [7:0] ctl_b_q; // Ratio, buffers, hold, done flag
  logic [7:0] clk_setup_q; // Master clock divider
  logic [7:0] amp_chan_q; // Input selects
  logic [7:0] amp_input_q; // Common-mode generator enable
  logic [23:0] result_q; // Latest accepted conversion
  // Two-entry buffer between filter and result
  logic [23:0] buf_mem_q [2]; // Storage entries
  logic wr_ptr_q; // Next entry to fill
  logic rd_ptr_q; // Next entry to drain
  logic [1:0] cnt_q; // Entries held
  // Decoded controls
  sdrc_pkg::sdrc_mode_t mode; // Operating mode from the control bits
  logic conv_on; // Modulator running and filter released
  logic push; // Word accepted from the filter
  logic pop; // Word leaves the buffer
  logic drain_ready; // Result side can take a word
  logic hold; // Result hold in force
  logic done_set; // Conversion completed and stored
  logic wr_ctl_b; // Write strobe to control b
  logic [23:0] sat_val; // Clamped incoming word
  sdrc_pkg::sdrc_ana_t ana_d; // Next analog enables
  logic [7:0] rdata_d; // Next read data

  // Mode decode: power-off over sleep over filter reset
  always_comb begin
    if (ctl_a_q[sdrc_pkg::CA_OFF_BIT]) begin
      mode = sdrc_pkg::MODE_PDOWN;
    end else if (ctl_a_q[sdrc_pkg::CA_SLEEP_BIT]) begin
      mode = sdrc_pkg::MODE_SLEEP;
    end else if (ctl_a_q[sdrc_pkg::CA_FRST_BIT]) begin
      mode = sdrc_pkg::MODE_RESET;
    end else begin
      mode = sdrc_pkg::MODE_NORMAL;
    end
  end

  // Conversions only run powered, awake and out of filter reset
  assign conv_on = (mode == sdrc_pkg::MODE_NORMAL);

  // Front-end enables per mode
  always_comb begin
    ana_d = '0;
    ana_d.common_mode_gen_en = amp_input_q[sdrc_pkg::AI_VCM_BIT];
    ana_d.reference_pair_ext = ctl_a_q[sdrc_pkg::CA_REFSEL_BIT];
    case (mode)
      sdrc_pkg::MODE_PDOWN: begin
        // Everything off, whatever sleep and reset say
        ana_d = '0;
      end
      sdrc_pkg::MODE_SLEEP: begin
        // Bandgap, amplifier and filter stay up, modulator off
        ana_d.bandgap_en = 1'b1;
        ana_d.pga_en = 1'b1;
        ana_d.filter_en = 1'b1;
      end
      sdrc_pkg::MODE_NORMAL, sdrc_pkg::MODE_RESET: begin
        ana_d.bandgap_en = 1'b1;
        ana_d.pga_en = 1'b1;
        ana_d.adc_en = 1'b1;
        ana_d.filter_en = 1'b1;
        ana_d.filter_reset = (mode == sdrc_pkg::MODE_RESET);
        // Sensor on when either input select routes it
        ana_d.temp_sense_en =
          (amp_chan_q[sdrc_pkg::AC_POS_LSB +: sdrc_pkg::CH_W] == sdrc_pkg::TEMP_CH_CODE) ||
          (amp_chan_q[sdrc_pkg::AC_NEG_LSB +: sdrc_pkg::CH_W] == sdrc_pkg::TEMP_CH_CODE);
        ana_d.neg_ref_buffer_en = ctl_b_q[sdrc_pkg::CB_NBUF_BIT];
        ana_d.pos_ref_buffer_en = ctl_b_q[sdrc_pkg::CB_PBUF_BIT];
      end
      default: begin
        ana_d = '0;
      end
    endcase
  end

  // Enables leave through flip-flops so the analog side sees no glitches
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ana_o <= '0;
      mode_o <= sdrc_pkg::MODE_PDOWN;
    end else begin
      ana_o <= ana_d;
      mode_o <= mode;
    end
  end

  // Setup fields for the clock divider and filter decimation
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_o <= '0;
    end else begin
      cfg_o.clock_divider_select <= clk_setup_q[sdrc_pkg::CKDIV_W-1:0];
      cfg_o.oversampling_select <= ctl_a_q[sdrc_pkg::CA_OSR_LSB +: sdrc_pkg::OSR_W];
      cfg_o.filter_ratio_select <= ctl_b_q[sdrc_pkg::CB_FILTER_RATIO_SELECT_LSB +: sdrc_pkg::FILTER_RATIO_SELECT_W];
      cfg_o.positive_input_select <= amp_chan_q[sdrc_pkg::AC_POS_LSB +: sdrc_pkg::CH_W];
      cfg_o.negative_input_select <= amp_chan_q[sdrc_pkg::AC_NEG_LSB +: sdrc_pkg::CH_W];
    end
  end

  // Clamp out-of-range filter words to the 24-bit limits
  always_comb begin
    if (filt_data_i > HI_LIM) begin
      sat_val = sdrc_pkg::RES_MAX;
    end else if (filt_data_i < LO_LIM) begin
      sat_val = sdrc_pkg::RES_MIN;
    end else begin
      sat_val = filt_data_i[23:0];
    end
  end

  // Buffer handshakes; a host read of a result byte stalls the drain
  // so the result stays fixed while a result byte strobe is held high
  assign drain_ready = !(reg_rd_i && (reg_addr_i >= sdrc_pkg::ADDR_SAMPLE_LOW) &&
                         (reg_addr_i <= sdrc_pkg::ADDR_SAMPLE_HIGH));
  assign filt_ready_o = conv_on && (cnt_q != 2'h2);
  assign push = filt_valid_i && filt_ready_o;
  assign pop = conv_on && (cnt_q != 2'h0) && drain_ready;
  assign hold = ctl_b_q[sdrc_pkg::CB_HOLD_BIT];
  assign done_set = pop && !hold;

  // Buffer pointers; flushed whenever conversions stop so stale words never land
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      cnt_q <= 2'h0;
    end else if (!conv_on) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_q <= !wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= !rd_ptr_q;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 2'h1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 2'h1;
      end
    end
  end

  // Buffer storage, data only
  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      buf_mem_q[wr_ptr_q] <= sat_val;
    end
  end

  // Result register has no reset; it is undefined until a conversion lands
  always_ff @(posedge clk_sys_i) begin
    if (done_set) begin
      result_q <= buf_mem_q[rd_ptr_q];
    end
  end

  // Control register writes
  assign wr_ctl_b = reg_wr_i && (reg_addr_i == sdrc_pkg::ADDR_CTL_B);
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctl_a_q <= sdrc_pkg::CTL_A_RST;
      clk_setup_q <= sdrc_pkg::CLK_SETUP_RST;
      amp_chan_q <= sdrc_pkg::AMP_CHAN_RST;
      amp_input_q <= sdrc_pkg::AMP_INPUT_RST;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        sdrc_pkg::ADDR_CTL_A: begin
          ctl_a_q <= reg_wdata_i;
        end
        sdrc_pkg::ADDR_CLK_SETUP: begin
          clk_setup_q <= reg_wdata_i & sdrc_pkg::CLK_SETUP_MASK;
        end
        sdrc_pkg::ADDR_AMP_CHAN: begin
          amp_chan_q <= reg_wdata_i & sdrc_pkg::AMP_CHAN_MASK;
        end
        sdrc_pkg::ADDR_AMP_INPUT: begin
          amp_input_q <= reg_wdata_i & sdrc_pkg::AMP_INPUT_MASK;
        end
        default: begin
          // Result bytes are read-only; control b is written below; other offsets ignore writes
        end
      endcase
    end
  end

  // Control b; hardware only sets the done flag and the set wins a clash
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctl_b_q <= sdrc_pkg::CTL_B_RST;
    end else begin
      if (wr_ctl_b) begin
        ctl_b_q <= reg_wdata_i & sdrc_pkg::CTL_B_MASK;
      end
      if (done_set) begin
        ctl_b_q[sdrc_pkg::CB_DONE_BIT] <= 1'b1;
      end
    end
  end

  // Read mux, unmapped offsets read as zero
  always_comb begin
    case (reg_addr_i)
      sdrc_pkg::ADDR_SAMPLE_LOW: rdata_d = result_q[7:0];
      sdrc_pkg::ADDR_SAMPLE_MID: rdata_d = result_q[15:8];
      sdrc_pkg::ADDR_SAMPLE_HIGH: rdata_d = result_q[23:16];
      sdrc_pkg::ADDR_CTL_A: rdata_d = ctl_a_q;
      sdrc_pkg::ADDR_CTL_B: rdata_d = ctl_b_q;
      sdrc_pkg::ADDR_CLK_SETUP: rdata_d = clk_setup_q;
      sdrc_pkg::ADDR_AMP_CHAN: rdata_d = amp_chan_q;
      sdrc_pkg::ADDR_AMP_INPUT: rdata_d = amp_input_q;
      default: rdata_d = 8'h00;
    endcase
  end

  // Read data is registered; it answers the cycle after the strobe
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_d;
    end
  end

  // Modulator never enabled unless power-off and sleep were both clear
  mod_power_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    ana_o.adc_en |-> !$past(ctl_a_q[sdrc_pkg::CA_OFF_BIT]) && !$past(ctl_a_q[sdrc_pkg::CA_SLEEP_BIT]))
    else $error("modulator enabled while off or asleep");

  // Filter reset bit holds the filter in reset and blocks the stream
  filt_reset_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (mode == sdrc_pkg::MODE_RESET) |-> !filt_ready_o ##1 ana_o.filter_reset)
    else $error("filter reset not applied");

  // Done flag rises the cycle after a stored conversion
  done_set_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    done_set |=> ctl_b_q[sdrc_pkg::CB_DONE_BIT])
    else $error("done flag not set after conversion");

  // Without hold the popped word becomes the result
  result_upd_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (pop && !hold) |=> result_q == $past(buf_mem_q[rd_ptr_q]))
    else $error("result not updated");

  // With hold the result stands still
  result_hold_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    hold |=> $stable(result_q))
    else $error("held result changed");

  // With hold and no host write the done flag does not move
  hold_done_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (hold && !wr_ctl_b) |=> $stable(ctl_b_q[sdrc_pkg::CB_DONE_BIT]))
    else $error("done flag changed while holding");

  // Power-off forces every enable low next cycle
  pdown_force_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    ctl_a_q[sdrc_pkg::CA_OFF_BIT] |=> (ana_o == '0) && (mode_o == sdrc_pkg::MODE_PDOWN))
    else $error("power-off not forcing power-down");

  // Reference select follows its control bit
  ref_sel_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    !ctl_a_q[sdrc_pkg::CA_OFF_BIT] |=> ana_o.reference_pair_ext == $past(ctl_a_q[sdrc_pkg::CA_REFSEL_BIT]))
    else $error("reference pair select wrong");

  // Over-range input is stored as the top code
  sat_high_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (push && (filt_data_i > HI_LIM)) |=> buf_mem_q[$past(wr_ptr_q)] == 24'h7FFFFF)
    else $error("positive clamp wrong");

  // Under-range input is stored as the bottom code
  sat_low_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (push && (filt_data_i < LO_LIM)) |=> buf_mem_q[$past(wr_ptr_q)] == 24'h800000)
    else $error("negative clamp wrong");

  // Low result byte read returns bits 7 to 0
  read_low_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (reg_rd_i && (reg_addr_i == sdrc_pkg::ADDR_SAMPLE_LOW)) |=> reg_rdata_o == $past(result_q[7:0]))
    else $error("low byte read wrong");

  // Temperature sensor follows the positive input select in normal mode
  temp_sel_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (conv_on && (amp_chan_q[2:0] == sdrc_pkg::TEMP_CH_CODE)) |=> ana_o.temp_sense_en)
    else $error("temperature sensor not enabled");

endmodule // sdrc_core
`default_nettype wire

/* File: dv/sdrc_src_model.sv */
// Decimation filter word source facing the block's stream input
`timescale 1ns/1ps
`default_nettype none
module sdrc_src_model #(
  parameter int RAW_W = 26 // Filter word width
) (
  // Clock
  input wire logic clk_sys_i,
  // Stream to the block
  input wire logic ready_i,
  output logic valid_o,
  output logic signed [RAW_W-1:0] data_o
);
  int n; // Bound on the wait for ready
  logic r; // Ready seen while inputs are settled
  int misses; // Words the block never took within the bound
  initial begin
    misses = 0;
    valid_o = 1'b0;
    data_o = '0;
  end
  // Offer one word and hold it until the block takes it
  task automatic send(input logic signed [RAW_W-1:0] w);
    @(negedge clk_sys_i);
    valid_o = 1'b1;
    data_o = w;
    n = 0;
    r = 1'b0;
    while (r !== 1'b1 && n < 50) begin
      #10;
      r = ready_i;
      @(posedge clk_sys_i);
      n++;
    end
    // A word left untaken is a failure the bench must count
    if (r !== 1'b1) misses++;
    @(negedge clk_sys_i);
    valid_o = 1'b0;
    // Released data is inverted so a stale word cannot pass for a fresh one
    data_o = ~w;
  endtask
endmodule // sdrc_src_model
`default_nettype wire

/* File: dv/tb_top.sv */
// Self-checking bench for the converter control and result block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int RAW_W = 26; // Filter word width
  logic clk_sys_i;
  logic nrst_i;
  logic [7:0] reg_addr_i;
  logic reg_wr_i;
  logic [7:0] reg_wdata_i;
  logic reg_rd_i;
  logic [7:0] reg_rdata_o;
  logic filt_valid_i;
  logic signed [RAW_W-1:0] filt_data_i;
  logic filt_ready_o;
  sdrc_pkg::sdrc_ana_t ana_o;
  sdrc_pkg::sdrc_cfg_t cfg_o;
  sdrc_pkg::sdrc_mode_t mode_o;
  int err_count; // Mismatches seen
  int checks_done; // Comparisons made
  int cyc; // Cycles run, for the hang guard
  logic [7:0] rv; // Last register read
  logic [23:0] res; // Last assembled result
  // Design under test
  sdrc_core #(.RAW_W(RAW_W)) uut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .filt_valid_i(filt_valid_i), .filt_data_i(filt_data_i), .filt_ready_o(filt_ready_o),
    .ana_o(ana_o), .cfg_o(cfg_o), .mode_o(mode_o));
  // Filter side model
  sdrc_src_model #(.RAW_W(RAW_W)) src (.clk_sys_i(clk_sys_i), .ready_i(filt_ready_o),
    .valid_o(filt_valid_i), .data_o(filt_data_i));
  // 10 MHz clock
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      close_out();
    end
  end
  // Compare and report
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // One register write, strobe for a single cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clk_sys_i);
    reg_wr_i = 1'b0;
  endtask
  // One register read; data is registered one edge after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge clk_sys_i);
    reg_rd_i = 1'b0;
    d = reg_rdata_o;
  endtask
  // Assemble the three result bytes
  task automatic rd_res(output logic [23:0] r);
    rd(sdrc_pkg::ADDR_SAMPLE_LOW, r[7:0]);
    rd(sdrc_pkg::ADDR_SAMPLE_MID, r[15:8]);
    rd(sdrc_pkg::ADDR_SAMPLE_HIGH, r[23:16]);
  endtask
  // Poll the done flag with a bound, as a host would
  task automatic wait_done;
    int i;
    for (i = 0; i < 20; i++) begin
      rd(sdrc_pkg::ADDR_CTL_B, rv);
      if (rv[sdrc_pkg::CB_DONE_BIT] === 1'b1) break;
    end
    chk("done flag", 1, rv[sdrc_pkg::CB_DONE_BIT]);
  endtask
  // Push one word, wait for done, compare result, then clear done
  task automatic conv(input logic signed [RAW_W-1:0] w, input logic [23:0] exp);
    src.send(w);
    wait_done();
    rd_res(res);
    chk("result", exp, res);
    wr(sdrc_pkg::ADDR_CTL_B, 8'h00);
  endtask
  // Write control a and check mode and stream readiness
  task automatic set_mode(input logic [7:0] v, input logic [1:0] m, input logic rdy);
    wr(sdrc_pkg::ADDR_CTL_A, v);
    repeat (2) @(negedge clk_sys_i);
    chk("mode", m, mode_o);
    chk("ready", rdy, filt_ready_o);
  endtask
  // Reset values and power-down state
  task automatic t_reset;
    rd(sdrc_pkg::ADDR_CTL_A, rv);
    chk("ctl_a reset", 8'h20, rv);
    rd(sdrc_pkg::ADDR_CTL_B, rv);
    chk("ctl_b reset", 8'h00, rv);
    chk("ana reset", 0, ana_o);
    chk("mode reset", sdrc_pkg::MODE_PDOWN, mode_o);
    $display("Test reset done");
  endtask
  // Host bring-up order: setup fields, power up, then a filter reset pulse
  task automatic t_setup;
    wr(sdrc_pkg::ADDR_CLK_SETUP, 8'h1F);
    wr(sdrc_pkg::ADDR_CTL_B, 8'h40);
    wr(sdrc_pkg::ADDR_AMP_CHAN, 8'h0A);
    wr(sdrc_pkg::ADDR_CTL_A, 8'h22);
    set_mode(8'h02, sdrc_pkg::MODE_NORMAL, 1'b1);
    set_mode(8'h42, sdrc_pkg::MODE_RESET, 1'b0);
    set_mode(8'h02, sdrc_pkg::MODE_NORMAL, 1'b1);
    chk("divider", 8'h1F, cfg_o.clock_divider_select);
    chk("oversampling", 8'h01, cfg_o.oversampling_select);
    chk("ratio", 8'h02, cfg_o.filter_ratio_select);
    chk("pos input", 8'h02, cfg_o.positive_input_select);
    chk("neg input", 8'h01, cfg_o.negative_input_select);
    $display("Test setup done");
  endtask
  // All four modes, including power-off over sleep and reset
  task automatic t_modes;
    logic [7:0] va [6] = '{8'hE0, 8'hC0, 8'h80, 8'h40, 8'h00, 8'h20};
    logic [1:0] ma [6] = '{sdrc_pkg::MODE_PDOWN, sdrc_pkg::MODE_SLEEP, sdrc_pkg::MODE_SLEEP,
      sdrc_pkg::MODE_RESET, sdrc_pkg::MODE_NORMAL, sdrc_pkg::MODE_PDOWN};
    logic ra [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
    int i;
    for (i = 0; i < 6; i++) set_mode(va[i], ma[i], ra[i]);
    set_mode(8'h40, sdrc_pkg::MODE_RESET, 1'b0);
    chk("filter reset", 1, ana_o.filter_reset);
    set_mode(8'h00, sdrc_pkg::MODE_NORMAL, 1'b1);
    $display("Test modes done");
  endtask
  // Coding, clamping and continuous update
  task automatic t_convert;
    conv(26'sh1000000, 24'h7FFFFF);
    conv(-26'sh1000000, 24'h800000);
    conv(26'sh0, 24'h000000);
    conv(-26'sh5, 24'hFFFFFB);
    conv(26'sh7FFFFF, 24'h7FFFFF);
    src.send(26'sh123456);
    conv(26'sh0ABCDE, 24'h0ABCDE);
    wr(sdrc_pkg::ADDR_SAMPLE_LOW, 8'h55);
    rd_res(res);
    chk("read-only result", 24'h0ABCDE, res);
    rd(sdrc_pkg::ADDR_CTL_B, rv);
    chk("done cleared", 0, rv[sdrc_pkg::CB_DONE_BIT]);
    $display("Test convert done");
  endtask
  // Hold keeps the result and leaves the done flag alone
  task automatic t_hold;
    wr(sdrc_pkg::ADDR_CTL_B, 8'h04);
    src.send(26'sh000777);
    repeat (5) @(negedge clk_sys_i);
    rd(sdrc_pkg::ADDR_CTL_B, rv);
    chk("done under hold", 8'h04, rv);
    rd_res(res);
    chk("held result", 24'h0ABCDE, res);
    wr(sdrc_pkg::ADDR_CTL_B, 8'h00);
    conv(26'sh000888, 24'h000888);
    $display("Test hold done");
  endtask
  // Stall the drain with result reads until the buffer refuses
  task automatic t_buffer;
    fork
      begin
        @(negedge clk_sys_i);
        reg_addr_i = sdrc_pkg::ADDR_SAMPLE_LOW;
        reg_rd_i = 1'b1;
        repeat (8) @(negedge clk_sys_i);
        reg_rd_i = 1'b0;
      end
      begin
        src.send(26'sh000111);
        src.send(26'sh000222);
        chk("buffer full", 0, filt_ready_o);
      end
    join
    repeat (4) @(negedge clk_sys_i);
    chk("buffer drained", 1, filt_ready_o);
    rd_res(res);
    chk("last buffered", 24'h000222, res);
    wr(sdrc_pkg::ADDR_CTL_B, 8'h00);
    $display("Test buffer done");
  endtask
  // Front-end enables follow their own controls
  task automatic t_analog;
    wr(sdrc_pkg::ADDR_AMP_CHAN, 8'h07);
    wr(sdrc_pkg::ADDR_AMP_INPUT, 8'h01);
    wr(sdrc_pkg::ADDR_CTL_B, 8'h18);
    wr(sdrc_pkg::ADDR_CTL_A, 8'h01);
    repeat (2) @(negedge clk_sys_i);
    chk("ref ext", 1, ana_o.reference_pair_ext);
    chk("vcm", 1, ana_o.common_mode_gen_en);
    chk("neg buf", 1, ana_o.neg_ref_buffer_en);
    chk("pos buf", 1, ana_o.pos_ref_buffer_en);
    chk("temp on", 1, ana_o.temp_sense_en);
    wr(sdrc_pkg::ADDR_AMP_CHAN, 8'h38);
    wr(sdrc_pkg::ADDR_CTL_B, 8'h08);
    wr(sdrc_pkg::ADDR_CTL_A, 8'h00);
    repeat (2) @(negedge clk_sys_i);
    chk("temp neg", 1, ana_o.temp_sense_en);
    chk("ref int", 0, ana_o.reference_pair_ext);
    chk("neg buf off", 0, ana_o.neg_ref_buffer_en);
    set_mode(8'h21, sdrc_pkg::MODE_PDOWN, 1'b0);
    chk("all off", 0, ana_o);
    $display("Test analog done");
  endtask
  // Verdict, the only place the run ends
  task automatic close_out;
    err_count += src.misses;
    $display("Checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    nrst_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wr_i = 1'b0;
    reg_wdata_i = 8'h00;
    reg_rd_i = 1'b0;
    err_count = 0;
    checks_done = 0;
    cyc = 0;
    repeat (3) @(negedge clk_sys_i);
    nrst_i = 1'b1;
    t_reset();
    t_setup();
    t_modes();
    t_convert();
    t_hold();
    t_buffer();
    t_analog();
    close_out();
  end
endmodule // tb_top
`default_nettype wire
